// ### pkg/glx_pkg.sv
// Purpose : Shared constants and carriers for the pin-level serial link core
// Assumes : One clock, mclk at 125 MHz; far-end clocks arrive as sampled inputs
// Notes   : The pacing, clock and pair reset values and the phase cycle count of the link live here

package glx_pkg;

  // Clock of the core, in its own unit, and the fastest link it must follow
  localparam int unsigned MCLK_PERIOD_PS = 8000;
  localparam int unsigned LINK_MAX_KHZ   = 156000;
  localparam int unsigned LINK_MIN_PS    = 1000000000 / LINK_MAX_KHZ;
  // Least phase of the forwarded clock in mclk cycles, rounded up, never zero
  localparam int unsigned RX_PHASE_RAW   = (LINK_MIN_PS / 2 + MCLK_PERIOD_PS - 1)
                                           / MCLK_PERIOD_PS;
  localparam int unsigned RX_PHASE_CYC   = (RX_PHASE_RAW < 1) ? 1 : RX_PHASE_RAW;

  // Word and pacing geometry
  localparam int unsigned WORD_W     = 4;
  localparam int unsigned PACE_W     = 2;
  localparam logic [1:0]  PACE_LAST  = 2'h3;
  localparam logic [1:0]  PACE_RST   = 2'h0;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned BUS_W      = 8;
  localparam int unsigned CORE_MULT  = 4;

  // Transmit rate generator defaults: bit tick = mclk * STEP / MOD / 2
  localparam int unsigned TX_STEP = 1;
  localparam int unsigned TX_MOD  = 2;

  // Idle and reset levels of the outgoing pairs
  localparam logic DATA_IDLE = 1'b0;
  localparam logic CLK_RST   = 1'b0;

  // Complementary pin pair
  typedef struct packed {
    logic p;
    logic n;
  } glx_pair_s;

  localparam glx_pair_s PAIR_IDLE = '{p: 1'b0, n: 1'b1};

endpackage

// ### rtl/glx_dual_clock_queue.sv
// Purpose : Word queue with valid/ready on both sides
// Assumes : Both sides run on mclk; the far domain is reduced to enables
// Notes   : Depth must be a power of two; full and empty are exact
`timescale 1ns/1ps

module glx_dual_clock_queue #(
  parameter int unsigned WIDTH = 4,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("queue depth must be a power of two");
    if (WIDTH < 1) $error("queue width must be positive");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  ////////////////////////////////////////////////////////////////////////////
  // Handshake; full stalls the writer, empty hides stale words
  assign in_ready  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_ff];

  // Storage; no reset so it maps onto plain RAM
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop)  rd_ptr_ff <= rd_ptr_ff + 1'b1;
      if (push && !pop) count_ff <= count_ff + 1'b1;
      else if (pop && !push) count_ff <= count_ff - 1'b1;
    end
  end

endmodule // glx_dual_clock_queue

// ### rtl/glx_rate_gen.sv
// Purpose : Derives the x2 and x1 transmit tick enables from mclk
// Assumes : STEP/MOD need not be a whole ratio; a phase accumulator spreads ticks
// Notes   : Stands in for the multiplying PLL; x1 is every other x2 tick
`timescale 1ns/1ps

module glx_rate_gen #(
  parameter int unsigned STEP = 1,
  parameter int unsigned MOD  = 2
) (
  input  wire logic mclk,
  input  wire logic rst,
  output logic      x2_en,
  output logic      x1_en
);

  localparam int unsigned AW = $clog2(MOD + STEP + 1);

  initial begin
    if (STEP < 1 || STEP > MOD) $error("rate step must lie in 1..MOD");
  end

  logic [AW-1:0] acc_ff;
  logic [AW-1:0] nxt_acc;
  logic          half_ff;
  logic          wrap;

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator wraps at MOD; each wrap is one x2 tick
  always_comb begin
    nxt_acc = acc_ff + AW'(STEP);
    wrap    = (nxt_acc >= AW'(MOD));
    if (wrap) nxt_acc = nxt_acc - AW'(MOD);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_ff <= '0;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  // Halving keeps x1 exactly phase-aligned with an x2 tick
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      half_ff <= 1'b0;
    end else if (wrap) begin
      half_ff <= ~half_ff;
    end
  end

  assign x2_en = wrap;
  assign x1_en = wrap && half_ff;

endmodule // glx_rate_gen

// ### rtl/glx_link.sv
// Purpose : Pin-level source-synchronous serial link core, receive and transmit
// Assumes : Differential conversion is external; all pins are single ended
//           and synchronous to mclk
// Notes   : Forwarded clocks are sampled, not used as clocks
`timescale 1ns/1ps

module glx_link #(
  parameter int unsigned DEPTH   = glx_pkg::FIFO_DEPTH,
  parameter int unsigned BUS_W   = glx_pkg::BUS_W,
  parameter int unsigned TX_STEP = glx_pkg::TX_STEP,
  parameter int unsigned TX_MOD  = glx_pkg::TX_MOD
) (
  input  wire logic                          mclk,
  input  wire logic                          rst,
  // Serial receive pins
  input  wire logic                          rx_clk_in,
  input  wire logic                          rx_data_in,
  // Serial receive words to the core
  input  wire logic                          rx_rdreq,
  output logic [glx_pkg::WORD_W-1:0]         rx_word,
  output logic                               rx_word_valid,
  output logic                               rx_avail,
  output logic                               rx_overrun,
  // Parallel bus receive pins
  input  wire logic                          bus_clk_in,
  input  wire logic [BUS_W-1:0]              bus_data_in,
  // Parallel bus words to the core
  input  wire logic                          bus_rdreq,
  output logic [BUS_W-1:0]                   bus_word,
  output logic                               bus_word_valid,
  output logic                               bus_avail,
  output logic                               bus_overrun,
  // Transmit words from the core
  input  wire logic                          tx_valid,
  output logic                               tx_ready,
  input  wire logic [glx_pkg::WORD_W-1:0]    tx_word,
  // Transmit pins
  output glx_pkg::glx_pair_s                 tx_data_pair,
  output glx_pkg::glx_pair_s                 tx_clk_pair
);

  localparam int unsigned WW = glx_pkg::WORD_W;

  initial begin
    if (BUS_W < 1) $error("bus width must be positive");
    if (DEPTH < 2) $error("queue depth too small");
  end

  // Bit index of a word as sent, most significant bit first
  function automatic logic [glx_pkg::PACE_W-1:0] msb_index(
    input logic [glx_pkg::PACE_W-1:0] pace
  );
    msb_index = glx_pkg::PACE_LAST - pace;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Serial receive: edge detect on the forwarded clock
  logic                rx_clk_d_ff;
  logic                rx_sample;
  logic [WW-1:0]       rx_shift_ff;
  logic [1:0]          rx_pace_ff;
  logic                rx_push;
  logic                rx_q_ready;
  logic                rx_q_valid;
  logic [WW-1:0]       rx_q_data;
  logic                rx_pop;

  // Falling forwarded edge is the inverted clock's rising edge, which sits
  // mid-eye when the far end launches on its rising edge. Limitation: mclk
  // must see each clock phase for RX_PHASE_CYC cycles, so 156 MHz links need
  // a faster mclk than the default.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_clk_d_ff <= 1'b0;
    end else begin
      rx_clk_d_ff <= rx_clk_in;
    end
  end

  assign rx_sample = rx_clk_d_ff && !rx_clk_in;

  // Shifter takes a bit on every sampling edge, newest bit at the bottom
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_shift_ff <= '0;
    end else if (rx_sample) begin
      rx_shift_ff <= {rx_shift_ff[WW-2:0], rx_data_in};
    end
  end

  // Two-bit pacing counter counts bits of the current word
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_pace_ff <= glx_pkg::PACE_RST;
    end else if (rx_sample) begin
      rx_pace_ff <= rx_pace_ff + 2'h1;
    end
  end

  // The word is complete one cycle after the fourth bit lands
  logic rx_word_done_ff;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_word_done_ff <= 1'b0;
    end else begin
      rx_word_done_ff <= rx_sample && (rx_pace_ff == glx_pkg::PACE_LAST);
    end
  end

  assign rx_push = rx_word_done_ff;

  // The link cannot be stalled, so a full queue drops the word and flags it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_overrun <= 1'b0;
    end else if (rx_push && !rx_q_ready) begin
      rx_overrun <= 1'b1;
    end
  end

  glx_dual_clock_queue #(
    .WIDTH (WW),
    .DEPTH (DEPTH)
  ) u_rx_queue (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (rx_push),
    .in_ready  (rx_q_ready),
    .in_data   (rx_shift_ff),
    .out_valid (rx_q_valid),
    .out_ready (rx_rdreq),
    .out_data  (rx_q_data)
  );

  assign rx_pop   = rx_q_valid && rx_rdreq;
  assign rx_avail = rx_q_valid;

  // Delivered word is registered; valid pulses one cycle per read
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_word       <= '0;
      rx_word_valid <= 1'b0;
    end else begin
      rx_word_valid <= rx_pop;
      if (rx_pop) rx_word <= rx_q_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parallel bus receive: capture on the bus clock's rising edge
  logic                bus_clk_d_ff;
  logic                bus_cap;
  logic                bus_q_ready;
  logic                bus_q_valid;
  logic [BUS_W-1:0]    bus_q_data;
  logic                bus_pop;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus_clk_d_ff <= 1'b0;
    end else begin
      bus_clk_d_ff <= bus_clk_in;
    end
  end

  assign bus_cap = !bus_clk_d_ff && bus_clk_in;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus_overrun <= 1'b0;
    end else if (bus_cap && !bus_q_ready) begin
      bus_overrun <= 1'b1;
    end
  end

  glx_dual_clock_queue #(
    .WIDTH (BUS_W),
    .DEPTH (DEPTH)
  ) u_bus_queue (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (bus_cap),
    .in_ready  (bus_q_ready),
    .in_data   (bus_data_in),
    .out_valid (bus_q_valid),
    .out_ready (bus_rdreq),
    .out_data  (bus_q_data)
  );

  assign bus_pop   = bus_q_valid && bus_rdreq;
  assign bus_avail = bus_q_valid;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus_word       <= '0;
      bus_word_valid <= 1'b0;
    end else begin
      bus_word_valid <= bus_pop;
      if (bus_pop) bus_word <= bus_q_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit: rate ticks, word queue, serializer and pin flops
  logic                x2_en;
  logic                x1_en;
  logic                tx_q_valid;
  logic [WW-1:0]       tx_q_data;
  logic                tx_take;
  logic [WW-1:0]       tx_word_ff;
  logic                tx_live_ff;
  logic [1:0]          tx_pace_ff;
  logic                tx_bit;
  logic                tx_tog_ff;

  // One generator feeds both pairs so data and clock never drift apart
  glx_rate_gen #(
    .STEP (TX_STEP),
    .MOD  (TX_MOD)
  ) u_rate (
    .mclk  (mclk),
    .rst   (rst),
    .x2_en (x2_en),
    .x1_en (x1_en)
  );

  // Core writes at its own pace; the queue absorbs the rate mismatch
  glx_dual_clock_queue #(
    .WIDTH (WW),
    .DEPTH (DEPTH)
  ) u_tx_queue (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_word),
    .out_valid (tx_q_valid),
    .out_ready (tx_take),
    .out_data  (tx_q_data)
  );

  // A new word is taken on the x1 tick that starts a four-bit slot
  assign tx_take = x1_en && (tx_pace_ff == glx_pkg::PACE_RST) && tx_q_valid;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_pace_ff <= glx_pkg::PACE_RST;
    end else if (x1_en && (tx_live_ff || tx_take)) begin
      tx_pace_ff <= tx_pace_ff + 2'h1;
    end
  end

  // Word holder; live marks a slot in flight, else the line idles low
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_word_ff <= '0;
      tx_live_ff <= 1'b0;
    end else if (x1_en) begin
      if (tx_take) begin
        tx_word_ff <= tx_q_data;
        tx_live_ff <= 1'b1;
      end else if (tx_pace_ff == glx_pkg::PACE_LAST) begin
        tx_live_ff <= 1'b0;
      end
    end
  end

  // Current bit; the first bit comes straight from the queue head
  always_comb begin
    if (tx_take) begin
      tx_bit = tx_q_data[msb_index(tx_pace_ff)];
    end else if (tx_live_ff) begin
      tx_bit = tx_word_ff[msb_index(tx_pace_ff)];
    end else begin
      tx_bit = glx_pkg::DATA_IDLE;
    end
  end

  // Data pair: true flop and inverted flop, loaded on the x1 tick
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_data_pair <= glx_pkg::PAIR_IDLE;
    end else if (x1_en) begin
      tx_data_pair.p <= tx_bit;
      tx_data_pair.n <= ~tx_bit;
    end
  end

  // Toggle flop halves x2 into a clock whose rise meets each data change
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_tog_ff <= glx_pkg::CLK_RST;
    end else if (x2_en) begin
      tx_tog_ff <= ~tx_tog_ff;
    end
  end

  // Clock pair registered like data; tog is high on each x1 tick, so p rises with data
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_clk_pair <= glx_pkg::PAIR_IDLE;
    end else if (x2_en) begin
      tx_clk_pair.p <= tx_tog_ff;
      tx_clk_pair.n <= ~tx_tog_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_fourth_bit;
    rx_sample && (rx_pace_ff == glx_pkg::PACE_LAST);
  endsequence

  sequence s_word_pushed;
    rx_push ##0 (rx_pace_ff == glx_pkg::PACE_RST);
  endsequence

  a_rx_mid_sample: assert property (@(posedge mclk) disable iff (rst)
    ($fell(rx_clk_in) && $past(rx_clk_in)) |=> rx_shift_ff[0] == $past(rx_data_in))
    else $error("bit not taken on falling forwarded edge");

  a_rx_shift_word: assert property (@(posedge mclk) disable iff (rst)
    rx_sample |=> rx_shift_ff[WW-1:1] == $past(rx_shift_ff[WW-2:0]))
    else $error("shifter did not move up by one");

  a_rx_pace_push: assert property (@(posedge mclk) disable iff (rst)
    s_fourth_bit |=> s_word_pushed)
    else $error("fourth bit did not push a word");

  a_rx_push_gate: assert property (@(posedge mclk) disable iff (rst)
    rx_push |-> $past(rx_sample) && $past(rx_pace_ff) == glx_pkg::PACE_LAST)
    else $error("word pushed outside a word boundary");

  a_bus_capture: assert property (@(posedge mclk) disable iff (rst)
    (bus_cap && bus_q_ready && !bus_q_valid) |=> bus_q_valid)
    else $error("bus edge did not fill the bus queue");

  a_read_gate: assert property (@(posedge mclk) disable iff (rst)
    (rx_word_valid |-> $past(rx_rdreq)) and (bus_word_valid |-> $past(bus_rdreq)))
    else $error("word delivered without read request");

  a_tx_pair_comp: assert property (@(posedge mclk) disable iff (rst)
    (tx_data_pair.p != tx_data_pair.n) && (tx_clk_pair.p != tx_clk_pair.n))
    else $error("output pair not complementary");

  a_tx_x1_hold: assert property (@(posedge mclk) disable iff (rst)
    !x1_en |=> $stable(tx_data_pair))
    else $error("data pair moved off the x1 tick");

  a_tx_clk_toggle: assert property (@(posedge mclk) disable iff (rst)
    x2_en |=> tx_clk_pair.p == $past(x1_en))
    else $error("forwarded clock out of step with the x2 ticks");

  a_tx_x1_align: assert property (@(posedge mclk) disable iff (rst)
    x1_en |-> x2_en)
    else $error("x1 tick not aligned to x2");

  a_tx_first_bit: assert property (@(posedge mclk) disable iff (rst)
    tx_take |=> tx_data_pair.p == $past(tx_q_data[WW-1]))
    else $error("first bit sent is not the word msb");

endmodule // glx_link

// ### tb/glx_far_end.sv
// Purpose : Far-end link partner: drives serial and bus pins, captures transmit words
// Assumes : All pins single ended and stepped on mclk rising edges
// Notes   : Forwarded clock stands low between words; released data shows inverse
`timescale 1ns/1ps

module glx_far_end #(
  parameter int unsigned BUS_W = 8
) (
  input  wire logic               mclk,
  output logic                    rx_clk_in,
  output logic                    rx_data_in,
  output logic                    bus_clk_in,
  output logic [BUS_W-1:0]        bus_data_in,
  input  wire glx_pkg::glx_pair_s tx_data_pair,
  input  wire glx_pkg::glx_pair_s tx_clk_pair,
  output logic [3:0]              cap_word,
  output logic                    cap_stb
);
  int         cap_left = 0;
  int         skip_cnt = 0;
  int         bit_cnt  = 0;
  logic       hunting  = 1'b1;
  logic       clk_p_d  = 1'b0;
  logic [3:0] shreg    = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Idle pin levels
  initial begin
    rx_clk_in   = 1'b0;
    rx_data_in  = 1'b0;
    bus_clk_in  = 1'b0;
    bus_data_in = '0;
    cap_word    = 4'h0;
    cap_stb     = 1'b0;
  end

  // Serial bits MSB first; data changes with the rising clock edge
  task automatic send_serial(input logic [3:0] w, input int nb, input int hi, input int lo);
    for (int i = 3; i > 3 - nb; i--) begin
      @(posedge mclk);
      rx_data_in <= w[i];
      rx_clk_in  <= 1'b1;
      repeat (hi) @(posedge mclk);
      rx_clk_in <= 1'b0;
      repeat (lo - 1) @(posedge mclk);
    end
    @(posedge mclk);
    rx_data_in <= ~w[4 - nb]; // Released: no stale value
  endtask

  // One bus word per rising bus clock, one cycle high
  task automatic send_bus(input logic [BUS_W-1:0] w);
    @(posedge mclk);
    bus_data_in <= w;
    bus_clk_in  <= 1'b1;
    @(posedge mclk);
    bus_clk_in  <= 1'b0;
    bus_data_in <= ~w;
  endtask

  task automatic arm(input int n);
    cap_left = n;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Sample data at the forwarded clock's falling edge, mid-bit; a leading
  // one-bit marks a marker word, which is skipped, since the link has no framing
  always @(posedge mclk) begin
    cap_stb <= 1'b0;
    clk_p_d <= tx_clk_pair.p;
    if (clk_p_d && !tx_clk_pair.p && cap_left > 0) begin
      if (hunting) begin
        if (tx_data_pair.p) begin
          hunting  = 1'b0;
          skip_cnt = 3;
          bit_cnt  = 0;
        end
      end else if (skip_cnt > 0) begin
        skip_cnt--;
      end else begin
        shreg = {shreg[2:0], tx_data_pair.p};
        bit_cnt++;
        if (bit_cnt == 4) begin
          cap_word <= shreg;
          cap_stb  <= 1'b1;
          bit_cnt  = 0;
          cap_left--;
          hunting  = (cap_left == 0);
        end
      end
    end
  end
endmodule // glx_far_end

// ### tb/glx_link_tb_top.sv
// Purpose : Self-checking bench for the serial link core
// Assumes : Default parameters; mclk 125 MHz
// Notes   : Drivers queue expected words, watchers pop and compare
`timescale 1ns/1ps

module glx_link_tb_top;
  logic                     mclk      = 1'b0;
  logic                     rst       = 1'b1;
  logic                     rx_rdreq  = 1'b0;
  logic                     bus_rdreq = 1'b0;
  logic                     tx_valid  = 1'b0;
  logic [3:0]               tx_word   = 4'h0;
  logic                     rx_clk_in;
  logic                     rx_data_in;
  logic                     bus_clk_in;
  logic [7:0]               bus_data_in;
  logic [3:0]               rx_word;
  logic                     rx_word_valid;
  logic                     rx_avail;
  logic                     rx_overrun;
  logic [7:0]               bus_word;
  logic                     bus_word_valid;
  logic                     bus_avail;
  logic                     bus_overrun;
  logic                     tx_ready;
  glx_pkg::glx_pair_s       tx_data_pair;
  glx_pkg::glx_pair_s       tx_clk_pair;
  logic [3:0]               cap_word;
  logic                     cap_stb;
  logic [1:0]               rd_mode   = 2'h0;
  logic                     saw_full  = 1'b0;
  logic [3:0]               w;
  logic [3:0]               rx_q[$];
  logic [3:0]               tx_q[$];
  logic [7:0]               bus_q[$];
  int                       error_cnt = 0;
  int                       tests_run = 0;
  int                       seed      = 99;
  int                       k;

  // 8 ns clock
  always #4 mclk = ~mclk;

  glx_link u_glx_link (
    .mclk(mclk), .rst(rst), .rx_clk_in(rx_clk_in), .rx_data_in(rx_data_in),
    .rx_rdreq(rx_rdreq), .rx_word(rx_word), .rx_word_valid(rx_word_valid),
    .rx_avail(rx_avail), .rx_overrun(rx_overrun), .bus_clk_in(bus_clk_in),
    .bus_data_in(bus_data_in), .bus_rdreq(bus_rdreq), .bus_word(bus_word),
    .bus_word_valid(bus_word_valid), .bus_avail(bus_avail), .bus_overrun(bus_overrun),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_word(tx_word),
    .tx_data_pair(tx_data_pair), .tx_clk_pair(tx_clk_pair)
  );

  glx_far_end u_glx_far_end (
    .mclk(mclk), .rx_clk_in(rx_clk_in), .rx_data_in(rx_data_in), .bus_clk_in(bus_clk_in),
    .bus_data_in(bus_data_in), .tx_data_pair(tx_data_pair), .tx_clk_pair(tx_clk_pair),
    .cap_word(cap_word), .cap_stb(cap_stb)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_flag(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Bounded wait until every expected word has been seen
  task automatic wait_empty(input string nm);
    k = 0;
    while ((rx_q.size() + bus_q.size() + tx_q.size()) > 0 && k < 3000) begin
      @(posedge mclk);
      k++;
    end
    chk_flag({nm, " drained"}, 1'b1, k < 3000);
    $display("test %s done", nm);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Read requests: off, random, or always; random reads stall the queues
  always @(posedge mclk) begin
    rx_rdreq  <= (rd_mode == 2'h2) || (rd_mode == 2'h1 && $random(seed) % 2 != 0);
    bus_rdreq <= (rd_mode == 2'h2) || (rd_mode == 2'h1 && $random(seed) % 2 != 0);
  end

  // Watchers: a word seen with no note queued means an unrequested release
  always @(posedge mclk) begin
    if (rx_word_valid === 1'b1) begin
      if (rx_q.size() == 0) chk_flag("rx_word_valid", 1'b0, 1'b1);
      else chk_word("rx_word", {4'h0, rx_q.pop_front()}, {4'h0, rx_word});
    end
    if (bus_word_valid === 1'b1) begin
      if (bus_q.size() == 0) chk_flag("bus_word_valid", 1'b0, 1'b1);
      else chk_word("bus_word", bus_q.pop_front(), bus_word);
    end
    if (cap_stb === 1'b1) begin
      if (tx_q.size() == 0) chk_flag("tx_cap", 1'b0, 1'b1);
      else chk_word("tx_cap", {4'h0, tx_q.pop_front()}, {4'h0, cap_word});
    end
    if (rst === 1'b0) begin
      chk_flag("tx_data_n", ~tx_data_pair.p, tx_data_pair.n);
      chk_flag("tx_clk_n", ~tx_clk_pair.p, tx_clk_pair.n);
    end
  end

  // Watchdog sized well above the longest expected run
  initial begin
    #(8 * 20000);
    error_cnt++;
    $display("[FAIL] watchdog expected done seen timeout");
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk_flag("tx_ready", 1'b1, tx_ready);
    chk_flag("rx_avail", 1'b0, rx_avail);
    chk_flag("bus_avail", 1'b0, bus_avail);
    chk_word("tx_data_pair", {6'h0, glx_pkg::PAIR_IDLE}, {6'h0, tx_data_pair});
    $display("test reset done");
    // Serial words at random clock phases, random reads
    rd_mode = 2'h1;
    for (int i = 0; i < 10; i++) begin
      w = 4'($random(seed));
      rx_q.push_back(w);
      u_glx_far_end.send_serial(w, 4, 1 + $unsigned($random(seed)) % 3,
                                1 + $unsigned($random(seed)) % 3);
    end
    wait_empty("serial");
    for (int i = 0; i < 10; i++) begin
      bus_q.push_back(8'($random(seed)));
      u_glx_far_end.send_bus(bus_q[$]);
    end
    wait_empty("bus");
    // Overfill both queues with no reads, then drain
    rd_mode = 2'h0;
    for (int i = 0; i < 17; i++) begin
      w = 4'($random(seed));
      if (i < 16) rx_q.push_back(w);
      u_glx_far_end.send_serial(w, 4, 1, 1);
      if (i < 16) bus_q.push_back({w, ~w});
      u_glx_far_end.send_bus({w, ~w});
    end
    repeat (3) @(posedge mclk);
    chk_flag("rx_overrun", 1'b1, rx_overrun);
    chk_flag("bus_overrun", 1'b1, bus_overrun);
    chk_flag("rx_avail", 1'b1, rx_avail);
    rd_mode = 2'h2;
    wait_empty("overrun");
    // Transmit: marker then 20 back-to-back words, waiting through each refusal
    u_glx_far_end.arm(20);
    @(posedge mclk);
    for (int i = 0; i < 21; i++) begin
      w = (i == 0) ? 4'h8 : 4'($random(seed));
      tx_valid <= 1'b1;
      tx_word  <= w;
      k = 0;
      do begin
        @(posedge mclk);
        k++;
        if (tx_ready !== 1'b1) saw_full = 1'b1;
      end while (tx_ready !== 1'b1 && k < 100);
      if (i > 0) tx_q.push_back(w);
    end
    tx_valid <= 1'b0;
    chk_flag("tx_full_seen", 1'b1, saw_full);
    wait_empty("transmit");
    // Reset in mid-word: half a word must not survive
    rd_mode = 2'h0;
    u_glx_far_end.send_serial(4'hF, 2, 1, 1);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk_flag("rx_overrun", 1'b0, rx_overrun);
    chk_flag("rx_avail", 1'b0, rx_avail);
    chk_word("tx_data_pair", {6'h0, glx_pkg::PAIR_IDLE}, {6'h0, tx_data_pair});
    rd_mode = 2'h1;
    rx_q.push_back(4'h5);
    u_glx_far_end.send_serial(4'h5, 4, 2, 2);
    wait_empty("mid reset");
    end_sim();
  end
endmodule // glx_link_tb_top
